/* core/rmi_params.svh */
`ifndef RMI_PARAMS_SVH
`define RMI_PARAMS_SVH

// ----------------------------------------
// Widths and reset values
// ----------------------------------------
`define RMI_NUM_IRQ 4
`define RMI_MODE_W 4
`define RMI_MODE_RST 4'h0
`define RMI_PHASE_W 2
`define RMI_PHASE_RST 2'h0

`endif

/* core/rmi_pkg.sv */
`include "rmi_params.svh"

package rmi_pkg;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [2:0] {
    RMI_ST_RESET = 3'h1,
    RMI_ST_LATCH = 3'h2,
    RMI_ST_RUN = 3'h4
  } rmi_state_e;

  typedef enum logic [2:0] {
    RMI_PWR_RUN = 3'h1,
    RMI_PWR_WAIT = 3'h2,
    RMI_PWR_STOP = 3'h4
  } rmi_pwr_e;

  typedef logic [`RMI_MODE_W-1:0] rmi_mode_t;

endpackage : rmi_pkg

/* core/rmi_mode_irq.sv */
`include "rmi_params.svh"
`timescale 1ns/1ps
`default_nettype none

module rmi_mode_irq
  import rmi_pkg::*;
#(
  parameter int NUM_IRQ = `RMI_NUM_IRQ
)
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Shared mode and interrupt pins, active low as interrupts
  input wire logic [NUM_IRQ-1:0] mode_irq_n_in,
  // Interrupt configuration from the core
  input wire logic [NUM_IRQ-1:0] irq_edge_mode_in,
  input wire logic [NUM_IRQ-1:0] irq_mask_in,
  input wire logic [NUM_IRQ-1:0] irq_clear_in,
  // Standby requests from the core
  input wire logic wait_enter_in,
  input wire logic stop_enter_in,
  // Outputs
  output logic chip_reset_out,
  output logic [`RMI_PHASE_W-1:0] phase_out,
  output logic [NUM_IRQ-1:0] operating_mode_register_out,
  output logic [NUM_IRQ-1:0] irq_pending_out,
  output logic irq_req_out,
  output logic wait_state_out,
  output logic stop_state_out,
  output logic wake_out
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [NUM_IRQ-1:0] sync1_reg;
  logic [NUM_IRQ-1:0] sync2_reg;
  logic [NUM_IRQ-1:0] sync3_reg;
  logic [NUM_IRQ-1:0] stable_reg;
  logic [NUM_IRQ-1:0] stable_next;

  always_comb
  begin
    stable_next = stable_reg;
    for (int i = 0; i < NUM_IRQ; i++)
    begin
      if (sync2_reg[i] == sync3_reg[i])
      begin
        stable_next[i] = sync2_reg[i];
      end
    end
  end

  // Kept out of reset so the mode levels are already sampled at release
  always_ff @(posedge clk_in)
  begin
    sync1_reg <= mode_irq_n_in;
    sync2_reg <= sync1_reg;
    sync3_reg <= sync2_reg;
  end

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      stable_reg <= '1;
    end
    else
    begin
      stable_reg <= stable_next;
    end
  end

  // ----------------------------------------
  // Reset sequencing and mode latch
  // ----------------------------------------
  rmi_state_e state_reg;
  rmi_state_e state_next;
  logic [NUM_IRQ-1:0] mode_reg;
  logic [NUM_IRQ-1:0] mode_next;
  logic [`RMI_PHASE_W-1:0] phase_reg;
  logic [`RMI_PHASE_W-1:0] phase_next;
  logic running;

  always_comb
  begin
    state_next = state_reg;
    mode_next = mode_reg;
    phase_next = phase_reg + `RMI_PHASE_W'(1);
    case (state_reg)
      RMI_ST_RESET:
      begin
        // Filter takes the settled pin level this cycle
        state_next = RMI_ST_LATCH;
      end
      RMI_ST_LATCH:
      begin
        mode_next = ~stable_reg;
        state_next = RMI_ST_RUN;
      end
      RMI_ST_RUN:
      begin
        state_next = RMI_ST_RUN;
      end
      default:
      begin
        state_next = RMI_ST_RESET;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      state_reg <= RMI_ST_RESET;
      mode_reg <= `RMI_MODE_RST;
      phase_reg <= `RMI_PHASE_RST;
    end
    else
    begin
      state_reg <= state_next;
      mode_reg <= mode_next;
      phase_reg <= phase_next;
    end
  end

  assign running = (state_reg == RMI_ST_RUN);
  assign chip_reset_out = !running;
  assign phase_out = phase_reg;
  assign operating_mode_register_out = mode_reg;

  // ----------------------------------------
  // Interrupt requests
  // ----------------------------------------
  logic [NUM_IRQ-1:0] prev_reg;
  logic [NUM_IRQ-1:0] pend_reg;
  logic [NUM_IRQ-1:0] pend_next;
  logic [NUM_IRQ-1:0] active;
  logic [NUM_IRQ-1:0] fall;

  always_comb
  begin
    fall = prev_reg & ~stable_reg;
    pend_next = '0;
    for (int i = 0; i < NUM_IRQ; i++)
    begin
      if (!running)
      begin
        pend_next[i] = 1'b0;
      end
      else if (irq_edge_mode_in[i])
      begin
        // Set wins over a clear in the same cycle
        pend_next[i] = fall[i] | (pend_reg[i] & ~irq_clear_in[i]);
      end
      else
      begin
        pend_next[i] = ~stable_reg[i];
      end
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      prev_reg <= '1;
      pend_reg <= '0;
    end
    else
    begin
      prev_reg <= stable_reg;
      pend_reg <= pend_next;
    end
  end

  assign active = pend_reg & ~irq_mask_in;
  assign irq_pending_out = pend_reg;
  assign irq_req_out = running & (|active);

  // ----------------------------------------
  // Standby states and wake-up
  // ----------------------------------------
  rmi_pwr_e pwr_reg;
  rmi_pwr_e pwr_next;
  logic wake_reg;
  logic wake_next;

  always_comb
  begin
    pwr_next = pwr_reg;
    wake_next = 1'b0;
    case (pwr_reg)
      RMI_PWR_RUN:
      begin
        if (running && stop_enter_in)
        begin
          pwr_next = RMI_PWR_STOP;
        end
        else if (running && wait_enter_in)
        begin
          pwr_next = RMI_PWR_WAIT;
        end
      end
      RMI_PWR_WAIT:
      begin
        if (|pend_reg)
        begin
          pwr_next = RMI_PWR_RUN;
          wake_next = 1'b1;
        end
      end
      RMI_PWR_STOP:
      begin
        if (pend_reg[0])
        begin
          pwr_next = RMI_PWR_RUN;
          wake_next = 1'b1;
        end
      end
      default:
      begin
        pwr_next = RMI_PWR_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      pwr_reg <= RMI_PWR_RUN;
      wake_reg <= 1'b0;
    end
    else
    begin
      pwr_reg <= pwr_next;
      wake_reg <= wake_next;
    end
  end

  assign wait_state_out = (pwr_reg == RMI_PWR_WAIT);
  assign stop_state_out = (pwr_reg == RMI_PWR_STOP);
  assign wake_out = wake_reg;

endmodule : rmi_mode_irq

`default_nettype wire

/* test/rmi_mode_irq_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module rmi_mode_irq_monitor
  import rmi_pkg::*;
#(parameter int NUM_IRQ = 4)
(
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [NUM_IRQ-1:0] mode_irq_n_in,
  input wire logic [NUM_IRQ-1:0] irq_edge_mode_in,
  input wire logic [NUM_IRQ-1:0] irq_mask_in,
  input wire logic [NUM_IRQ-1:0] irq_clear_in,
  input wire logic chip_reset_out,
  input wire logic [1:0] phase_out,
  input wire logic [NUM_IRQ-1:0] operating_mode_register_out,
  input wire logic [NUM_IRQ-1:0] irq_pending_out,
  input wire logic irq_req_out,
  input wire logic wait_state_out,
  input wire logic stop_state_out,
  input wire logic wake_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  sequence s_wake;
    wake_out ##1 !wake_out;
  endsequence
  property p_rst;
    disable iff (1'b0) !nrst_in |-> chip_reset_out && phase_out == 2'h0 && irq_pending_out == '0;
  endproperty
  a_rst: assert property (p_rst) else $error("bad reset");
  property p_phase;
    $past(nrst_in) |-> phase_out == 2'($past(phase_out) + 2'h1);
  endproperty
  a_phase: assert property (p_phase) else $error("phase stuck");
  property p_latch;
    $fell(chip_reset_out) |-> operating_mode_register_out == ~$past(mode_irq_n_in, 2);
  endproperty
  a_latch: assert property (p_latch) else $error("bad mode");
  property p_hold;
    !chip_reset_out ##1 !chip_reset_out |-> $stable(operating_mode_register_out);
  endproperty
  a_hold: assert property (p_hold) else $error("mode moved");
  property p_req;
    !chip_reset_out |-> irq_req_out == |(irq_pending_out & ~irq_mask_in);
  endproperty
  a_req: assert property (p_req) else $error("bad req");
  property p_stop;
    stop_state_out && irq_pending_out[0] |=> s_wake and !stop_state_out;
  endproperty
  a_stop: assert property (p_stop) else $error("no stop exit");
  property p_wait;
    wait_state_out && |irq_pending_out |=> s_wake and !wait_state_out;
  endproperty
  a_wait: assert property (p_wait) else $error("no wait exit");
  property p_edge;
    |(irq_edge_mode_in & irq_pending_out & ~irq_clear_in) |=>
      (irq_pending_out | ~$past(irq_edge_mode_in & irq_pending_out & ~irq_clear_in)) == '1;
  endproperty
  a_edge: assert property (p_edge) else $error("edge lost");
endmodule : rmi_mode_irq_monitor
bind rmi_mode_irq rmi_mode_irq_monitor #(.NUM_IRQ(NUM_IRQ)) MON (.*);
`default_nettype wire

/* test/rmi_board.sv */
`timescale 1ns/1ps
`default_nettype none
module rmi_board
(
  input wire logic clk_in,
  input wire logic rst_req_in,
  input wire logic [3:0] mode_in,
  input wire logic [3:0] irq_n_in,
  output logic nrst_out,
  output logic [3:0] pins_out
);
  logic [2:0] cnt_reg = 3'h0;
  initial nrst_out <= 1'b0;
  always @(posedge clk_in)
  begin
    nrst_out <= !rst_req_in;
    cnt_reg <= rst_req_in ? 3'h0 : cnt_reg + 3'(cnt_reg != 3'h7);
  end
  // Mode held well past release
  assign pins_out = cnt_reg < 3'h4 ? mode_in : irq_n_in;
endmodule : rmi_board
`default_nettype wire

/* test/rmi_mode_irq_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module rmi_mode_irq_tb;
  import rmi_pkg::*;
  logic clk = 0, rq = 1, nrst, wt = 0, sp = 0, crst, req, wst, sst, wk;
  logic [3:0] md = 0, irn = 4'hF, pins, edg = 0, msk = 0, clr = 0, pnd, operating_mode_register;
  logic [1:0] ph;
  int error_cnt = 0, checks = 0, j, k;
  initial forever #12.5 clk = ~clk;
  rmi_board BRD (.clk_in(clk), .rst_req_in(rq), .mode_in(md), .irq_n_in(irn),
    .nrst_out(nrst), .pins_out(pins));
  rmi_mode_irq DUT (.clk_in(clk), .nrst_in(nrst), .mode_irq_n_in(pins),
    .irq_edge_mode_in(edg), .irq_mask_in(msk), .irq_clear_in(clr), .wait_enter_in(wt),
    .stop_enter_in(sp), .chip_reset_out(crst), .phase_out(ph),
    .operating_mode_register_out(operating_mode_register), .irq_pending_out(pnd), .irq_req_out(req),
    .wait_state_out(wst), .stop_state_out(sst), .wake_out(wk));
  task chk(input string n, input logic [3:0] e, input logic [3:0] g);
    checks++;
    if (g !== e)
    begin
      $display("unexpected %s exp %h got %h", n, e, g);
      error_cnt++;
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task wake;
    for (j = 0; j < 20 && wk !== 1'b1; j++) @(posedge clk);
  endtask : wake
  task report_and_stop;
    if (error_cnt == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  initial
  begin
    #100us error_cnt++;
    report_and_stop();
  end
  initial
  begin
    void'($urandom(36895));
    for (int i = 0; i < 4; i++)
    begin
      md <= (i == 0) ? 4'hF : (i == 1) ? 4'h0 : 4'($urandom);
      rq <= 1;
      cyc(6);
      chk("phase", 0, ph);
      chk("hold", 1, crst);
      rq <= 0;
      cyc(8);
      chk("mode", ~md, operating_mode_register);
    end
    for (k = 0; k < 4; k++)
    begin
      irn <= ~(4'h1 << k);
      cyc(6);
      chk("pend", 4'h1 << k, pnd);
      chk("req", 1, req);
      msk <= 4'h1 << k;
      cyc(2);
      chk("masked", 0, req);
      msk <= 0;
      irn <= 4'hF;
      cyc(6);
      chk("level", 0, pnd);
    end
    k = $urandom % 4;
    edg <= 4'hF;
    irn <= ~(4'h1 << k);
    cyc(3);
    irn <= 4'hF;
    cyc(10);
    chk("edge", 4'h1 << k, pnd);
    clr <= 4'h1 << k;
    cyc(1);
    clr <= 0;
    cyc(2);
    chk("clear", 0, pnd);
    irn <= ~(4'h1 << k);
    cyc(3);
    irn <= 4'hF;
    cyc(1);
    clr <= 4'h1 << k;
    cyc(1);
    clr <= 0;
    cyc(3);
    chk("set wins", 4'h1 << k, pnd);
    edg <= 0;
    wt <= 1;
    cyc(1);
    wt <= 0;
    cyc(2);
    chk("wait", 1, wst);
    irn <= 4'h7;
    wake();
    chk("wake", 1, wk);
    chk("wait", 0, wst);
    irn <= 4'hF;
    cyc(6);
    sp <= 1;
    cyc(1);
    sp <= 0;
    cyc(2);
    irn <= 4'hD;
    cyc(8);
    chk("stop", 1, sst);
    irn <= 4'hC;
    wake();
    chk("stop", 0, sst);
    chk("mode", ~md, operating_mode_register);
    report_and_stop();
  end
endmodule : rmi_mode_irq_tb
`default_nettype wire
